// >>> dspg_pkg.sv
// package: data-space paging and nvm control constants
package dspg_pkg;
    localparam logic [7:0] WINDOW_BASE_ADDR = 8'hc9;
    localparam logic [7:0] PAGE_SELECT_ADDR = 8'hcb;
    localparam logic [7:0] NVM_CONTROL_ADDR = 8'hdf;
    localparam logic [7:0] NVM_CONTROL_RESET = 8'h00;
    localparam logic [7:0] WINDOW_LO_ADDR = 8'h40;
    localparam logic [7:0] WINDOW_HI_ADDR = 8'h7f;
    localparam logic [7:0] BANK_HI_ADDR = 8'h3f;
    localparam int WINDOW_POS_WIDTH = 6;
    localparam int OFFSET_WIDTH = 6;
    localparam int ROW_BYTES = 8;
    // page select bits
    localparam int SEL_NVM_PAGE0 = 0;
    localparam int SEL_NVM_PAGE1 = 1;
    localparam int SEL_RAM_PAGE1 = 3;
    localparam int SEL_RAM_PAGE2 = 4;
    localparam logic [7:0] PAGE_SELECT_MASK = 8'h1b;
    // nvm control bits
    localparam int CTL_PROGRAM_ENABLE = 0;
    localparam int CTL_BUSY = 1;
    localparam int CTL_ROW_MODE = 2;
    localparam int CTL_ROW_START = 3;
    localparam int CTL_STANDBY = 6;
    // programming time of one cell cycle
    localparam int PROGRAM_TIME_US = 5;
    localparam int CLOCK_MHZ = 125;
    localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLOCK_MHZ;
endpackage

// >>> dspg_row_latch.sv
// row latch bank collecting bytes for a row-mode write
`timescale 1ns/1ns
module dspg_row_latch #(
    parameter int ROW_BYTES = 8
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // control
    input wire logic clear,
    input wire logic load,
    input wire logic [$clog2(ROW_BYTES)-1:0] load_index,
    input wire logic [7:0] load_data,
    // contents
    output logic [ROW_BYTES-1:0] filled,
    output logic [ROW_BYTES*8-1:0] data
);
    logic [ROW_BYTES-1:0] filled_reg;
    logic [7:0] data_reg [ROW_BYTES];

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            filled_reg <= '0;
        end
        else if (clear)
        begin
            filled_reg <= '0;
        end
        else if (load)
        begin
            filled_reg[load_index] <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (load && !clear)
        begin
            data_reg[load_index] <= load_data;
        end
    end

    always_comb
    begin
        for (int i = 0; i < ROW_BYTES; i++)
        begin
            data[i*8 +: 8] = data_reg[i];
        end
    end

    assign filled = filled_reg;
endmodule

// >>> dspg_paging.sv
// data-space paging: rom window, page select and nvm control
`timescale 1ns/1ns
// Behaviour
// - reads at 40h..7Fh return program-memory bytes
// - program address is window base over the six low address bits
// - only base bits 5..0 are kept; bits 7,6 do nothing
// - window base at C9h is write-only
// - reset leaves window base untouched; software loads it first
// - page select bits pick RAM page 2/1 or nvm page 1/0
// - addresses 00h..3Fh go to the selected page, same offset
// - page select at CBh is write-only and not cleared by reset
// - standby must be clear for nvm reads and writes; else no effect; row start does not check it
// - programming starts only with program enable set
// - busy stands for the whole programming cycle; accesses then ignored
// - idle nvm reads outside row mode behave like plain data reads
// - single-byte mode and row mode of up to 8 bytes
// - in single-byte mode written data goes straight to the programming path
// - while busy, control writes ignored, only busy reads back
// - row mode latches the row; other-row accesses are dropped
// - setting row mode clears the latches; only loaded bytes program
// - row mode clears itself when programming completes
// - row start ignored unless program enable and row mode set
// - control at DFh resets to 00h with the documented bit layout
// - row start clears itself at end of programming
// - access while busy is aborted; running cycle completes
module dspg_paging #(
    parameter int PROGRAM_CYCLES = dspg_pkg::PROGRAM_CYCLES,
    parameter int ROW_BYTES = dspg_pkg::ROW_BYTES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // cpu data-space bus
    input wire logic [7:0] cpu_addr,
    input wire logic cpu_read,
    input wire logic cpu_write,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic cpu_rdata_valid,
    // program memory read port
    output logic [11:0] prog_addr,
    input wire logic [7:0] prog_rdata,
    // banked ram page
    output logic ram_page_sel,
    output logic ram_page_write,
    output logic [5:0] ram_page_offset,
    output logic [7:0] ram_page_wdata,
    input wire logic [7:0] ram_page_rdata,
    // nvm array
    output logic nvm_page,
    output logic [5:0] nvm_offset,
    output logic nvm_read,
    input wire logic [7:0] nvm_rdata,
    output logic nvm_program,
    output logic [ROW_BYTES-1:0] nvm_byte_enable,
    output logic [ROW_BYTES*8-1:0] nvm_program_data,
    // status
    output logic nvm_busy_flag,
    output logic nvm_standby
);
    localparam int IDX_W = $clog2(ROW_BYTES);
    localparam int CNT_W = $clog2(PROGRAM_CYCLES + 1);

    typedef enum logic [1:0] {DSPG_IDLE, DSPG_PROGRAM, DSPG_DONE} dspg_state_type;

    // decode helpers
    function automatic logic dspg_in_bank(input logic [7:0] a);
        dspg_in_bank = (a <= dspg_pkg::BANK_HI_ADDR);
    endfunction

    function automatic logic dspg_in_window(input logic [7:0] a);
        dspg_in_window = (a >= dspg_pkg::WINDOW_LO_ADDR) && (a <= dspg_pkg::WINDOW_HI_ADDR);
    endfunction

    // =====================================================
    // registers
    logic [5:0] rom_window_position_reg;
    logic [7:0] page_select_reg;
    logic nvm_standby_reg;
    logic nvm_program_enable_reg;
    logic row_mode_enable_reg;
    logic row_write_start_reg;
    logic nvm_busy_flag_reg;
    logic [2:0] row_addr_reg;
    logic nvm_row_page_reg;
    dspg_state_type state_reg;
    logic [CNT_W-1:0] count_reg;
    logic single_byte_write_mode_reg;
    logic [IDX_W-1:0] byte_index_reg;
    logic [7:0] byte_data_reg;

    logic [7:0] cpu_rdata_reg;
    logic cpu_rdata_valid_reg;
    logic [11:0] prog_addr_reg;
    logic ram_page_sel_reg;
    logic ram_page_write_reg;
    logic [5:0] ram_page_offset_reg;
    logic [7:0] ram_page_wdata_reg;
    logic nvm_page_reg;
    logic [5:0] nvm_offset_reg;
    logic nvm_read_reg;
    logic nvm_program_reg;
    logic [ROW_BYTES-1:0] nvm_byte_enable_reg;
    logic [ROW_BYTES*8-1:0] nvm_program_data_reg;

    // =====================================================
    // access decode
    logic bank_access;
    logic nvm_selected;
    logic nvm_usable;
    logic nvm_wr;
    logic row_match;
    logic ctl_write;
    logic row_mode_set;
    logic start_request;
    logic latch_load;
    logic [ROW_BYTES-1:0] latch_filled;
    logic [ROW_BYTES*8-1:0] latch_data;
    logic [7:0] ctl_next;

    assign bank_access = dspg_in_bank(cpu_addr);
    assign nvm_selected = page_select_reg[dspg_pkg::SEL_NVM_PAGE0]
        | page_select_reg[dspg_pkg::SEL_NVM_PAGE1];
    // no access while standby or busy
    assign nvm_usable = nvm_selected && !nvm_standby_reg && !nvm_busy_flag_reg;
    assign row_match = (cpu_addr[5:3] == row_addr_reg)
        && (nvm_row_page_reg == page_select_reg[dspg_pkg::SEL_NVM_PAGE1]);
    assign nvm_wr = cpu_write && bank_access && nvm_usable && nvm_program_enable_reg;
    assign ctl_write = cpu_write && (cpu_addr == dspg_pkg::NVM_CONTROL_ADDR)
        && !nvm_busy_flag_reg;
    assign ctl_next = cpu_wdata;
    assign row_mode_set = ctl_write && ctl_next[dspg_pkg::CTL_ROW_MODE]
        && !row_mode_enable_reg;
    // row start only honoured with enable and row mode already set
    assign start_request = ctl_write && ctl_next[dspg_pkg::CTL_ROW_START]
        && nvm_program_enable_reg && row_mode_enable_reg && (|latch_filled);
    // in row mode, only the latched row accepts bytes; the first byte latches the row
    assign latch_load = nvm_wr && row_mode_enable_reg
        && (row_match || !(|latch_filled));

    dspg_row_latch #(
        .ROW_BYTES(ROW_BYTES)
    )
    u_row_latch (
        .clk(clk),
        .reset_n(reset_n),
        .clear(row_mode_set),
        .load(latch_load),
        .load_index(cpu_addr[IDX_W-1:0]),
        .load_data(cpu_wdata),
        .filled(latch_filled),
        .data(latch_data)
    );

    // =====================================================
    // write-only paging registers: no reset, so contents survive reset
    always_ff @(posedge clk)
    begin
        if (cpu_write && cpu_addr == dspg_pkg::WINDOW_BASE_ADDR)
        begin
            rom_window_position_reg <= cpu_wdata[5:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (cpu_write && cpu_addr == dspg_pkg::PAGE_SELECT_ADDR)
        begin
            page_select_reg <= cpu_wdata & dspg_pkg::PAGE_SELECT_MASK;
        end
    end

    // =====================================================
    // nvm control register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nvm_standby_reg <= dspg_pkg::NVM_CONTROL_RESET[dspg_pkg::CTL_STANDBY];
            nvm_program_enable_reg <= dspg_pkg::NVM_CONTROL_RESET[dspg_pkg::CTL_PROGRAM_ENABLE];
            row_mode_enable_reg <= dspg_pkg::NVM_CONTROL_RESET[dspg_pkg::CTL_ROW_MODE];
            row_write_start_reg <= dspg_pkg::NVM_CONTROL_RESET[dspg_pkg::CTL_ROW_START];
        end
        else if (state_reg == DSPG_DONE)
        begin
            row_mode_enable_reg <= 1'b0;
            row_write_start_reg <= 1'b0;
        end
        else if (ctl_write)
        begin
            nvm_standby_reg <= ctl_next[dspg_pkg::CTL_STANDBY];
            nvm_program_enable_reg <= ctl_next[dspg_pkg::CTL_PROGRAM_ENABLE];
            row_mode_enable_reg <= ctl_next[dspg_pkg::CTL_ROW_MODE];
            row_write_start_reg <= start_request;
        end
    end

    // row address is captured by the first byte after row mode was set
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            row_addr_reg <= 3'h0;
            nvm_row_page_reg <= 1'b0;
        end
        else if (nvm_wr && row_mode_enable_reg && !(|latch_filled))
        begin
            row_addr_reg <= cpu_addr[5:3];
            nvm_row_page_reg <= page_select_reg[dspg_pkg::SEL_NVM_PAGE1];
        end
    end

    // =====================================================
    // programming sequencer
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= DSPG_IDLE;
            count_reg <= '0;
            nvm_busy_flag_reg <= 1'b0;
            single_byte_write_mode_reg <= 1'b0;
            byte_index_reg <= '0;
            byte_data_reg <= 8'h00;
        end
        else
        begin
            case (state_reg)
                DSPG_IDLE:
                begin
                    count_reg <= CNT_W'(PROGRAM_CYCLES);
                    if (start_request)
                    begin
                        state_reg <= DSPG_PROGRAM;
                        nvm_busy_flag_reg <= 1'b1;
                        single_byte_write_mode_reg <= 1'b0;
                    end
                    else if (nvm_wr && !row_mode_enable_reg)
                    begin
                        state_reg <= DSPG_PROGRAM;
                        nvm_busy_flag_reg <= 1'b1;
                        single_byte_write_mode_reg <= 1'b1;
                        byte_index_reg <= cpu_addr[IDX_W-1:0];
                        byte_data_reg <= cpu_wdata;
                    end
                end
                DSPG_PROGRAM:
                begin
                    // accesses meanwhile are dropped; the cycle runs on
                    count_reg <= count_reg - CNT_W'(1);
                    if (count_reg == CNT_W'(1))
                    begin
                        state_reg <= DSPG_DONE;
                    end
                end
                DSPG_DONE:
                begin
                    nvm_busy_flag_reg <= 1'b0;
                    state_reg <= DSPG_IDLE;
                end
                default:
                begin
                    state_reg <= DSPG_IDLE;
                    nvm_busy_flag_reg <= 1'b0;
                end
            endcase
        end
    end

    // single-byte cycles carry their own row and page
    logic [2:0] byte_row_reg;
    logic byte_page_reg;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            byte_row_reg <= 3'h0;
            byte_page_reg <= 1'b0;
        end
        else if (state_reg == DSPG_IDLE && nvm_wr && !row_mode_enable_reg)
        begin
            byte_row_reg <= cpu_addr[5:3];
            byte_page_reg <= page_select_reg[dspg_pkg::SEL_NVM_PAGE1];
        end
    end

    // program strobe and data to the array, held for the whole cycle
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nvm_program_reg <= 1'b0;
            nvm_byte_enable_reg <= '0;
            nvm_program_data_reg <= '0;
        end
        else
        begin
            nvm_program_reg <= (state_reg == DSPG_PROGRAM);
            if (single_byte_write_mode_reg)
            begin
                nvm_byte_enable_reg <= ROW_BYTES'(1) << byte_index_reg;
                nvm_program_data_reg <= {ROW_BYTES{byte_data_reg}};
            end
            else
            begin
                nvm_byte_enable_reg <= latch_filled;
                nvm_program_data_reg <= latch_data;
            end
        end
    end

    // =====================================================
    // read path and page steering
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prog_addr_reg <= 12'h000;
            ram_page_sel_reg <= 1'b0;
            ram_page_write_reg <= 1'b0;
            ram_page_offset_reg <= 6'h00;
            ram_page_wdata_reg <= 8'h00;
            nvm_page_reg <= 1'b0;
            nvm_offset_reg <= 6'h00;
            nvm_read_reg <= 1'b0;
        end
        else
        begin
            prog_addr_reg <= {rom_window_position_reg, cpu_addr[5:0]};
            ram_page_sel_reg <= bank_access && (cpu_read || cpu_write)
                && page_select_reg[dspg_pkg::SEL_RAM_PAGE2];
            ram_page_write_reg <= cpu_write && bank_access
                && page_select_reg[dspg_pkg::SEL_RAM_PAGE2];
            ram_page_offset_reg <= cpu_addr[5:0];
            ram_page_wdata_reg <= cpu_wdata;
            // while a cycle runs the array must see the row being programmed,
            // not whatever address the cpu is touching meanwhile
            if (state_reg != DSPG_IDLE)
            begin
                nvm_page_reg <= single_byte_write_mode_reg ? byte_page_reg
                    : nvm_row_page_reg;
                nvm_offset_reg <= {(single_byte_write_mode_reg ? byte_row_reg
                    : row_addr_reg), 3'h0};
            end
            else
            begin
                nvm_page_reg <= row_mode_enable_reg ? nvm_row_page_reg
                    : page_select_reg[dspg_pkg::SEL_NVM_PAGE1];
                nvm_offset_reg <= cpu_addr[5:0];
            end
            nvm_read_reg <= cpu_read && bank_access && nvm_usable
                && !row_mode_enable_reg;
        end
    end

    // read data returns one cycle after the request
    logic [1:0] src_reg;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            src_reg <= 2'h0;
            cpu_rdata_valid_reg <= 1'b0;
        end
        else
        begin
            cpu_rdata_valid_reg <= cpu_read && (dspg_in_window(cpu_addr) || bank_access
                || cpu_addr == dspg_pkg::NVM_CONTROL_ADDR);
            if (dspg_in_window(cpu_addr))
                src_reg <= 2'h1;
            else if (cpu_addr == dspg_pkg::NVM_CONTROL_ADDR)
                src_reg <= 2'h2;
            else
                src_reg <= 2'h3;
        end
    end

    always_comb
    begin
        case (src_reg)
            2'h1: cpu_rdata_reg = prog_rdata;
            // only busy reads back from the control register
            2'h2: cpu_rdata_reg = {6'h00, nvm_busy_flag_reg, 1'b0};
            2'h3: cpu_rdata_reg = ram_page_sel_reg ? ram_page_rdata
                : (nvm_read_reg ? nvm_rdata : 8'h00);
            default: cpu_rdata_reg = 8'h00;
        endcase
    end

    assign cpu_rdata = cpu_rdata_reg;
    assign cpu_rdata_valid = cpu_rdata_valid_reg;
    assign prog_addr = prog_addr_reg;
    assign ram_page_sel = ram_page_sel_reg;
    assign ram_page_write = ram_page_write_reg;
    assign ram_page_offset = ram_page_offset_reg;
    assign ram_page_wdata = ram_page_wdata_reg;
    assign nvm_page = nvm_page_reg;
    assign nvm_offset = nvm_offset_reg;
    assign nvm_read = nvm_read_reg;
    assign nvm_program = nvm_program_reg;
    assign nvm_byte_enable = nvm_byte_enable_reg;
    assign nvm_program_data = nvm_program_data_reg;
    assign nvm_busy_flag = nvm_busy_flag_reg;
    assign nvm_standby = nvm_standby_reg;
endmodule

// >>> dspg_paging_props.sv
// checker: port-level properties of the data-space paging block
`timescale 1ns/1ns
module dspg_paging_props #(
    parameter int PROGRAM_CYCLES = 4
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // cpu bus
    input wire logic [7:0] cpu_addr,
    input wire logic cpu_read,
    input wire logic cpu_write,
    input wire logic [7:0] cpu_wdata,
    input wire logic [7:0] cpu_rdata,
    input wire logic cpu_rdata_valid,
    // memories
    input wire logic [11:0] prog_addr,
    input wire logic [7:0] prog_rdata,
    input wire logic ram_page_sel,
    input wire logic ram_page_write,
    input wire logic [5:0] ram_page_offset,
    input wire logic [7:0] ram_page_wdata,
    input wire logic nvm_program,
    // status
    input wire logic nvm_busy_flag,
    input wire logic nvm_standby
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    int busy_cnt_reg;
    // counts busy cycles so the full programming length can be checked
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            busy_cnt_reg <= 0;
        else
            busy_cnt_reg <= nvm_busy_flag ? busy_cnt_reg + 1 : 0;
    end
    // ====
    // properties
    property p_win_read;
        cpu_read && cpu_addr inside {[8'h40:8'h7f]} |=> cpu_rdata_valid
            && cpu_rdata == prog_rdata && prog_addr[5:0] == $past(cpu_addr[5:0]);
    endproperty
    a_win_read: assert property (p_win_read)
        else $error("window read not served from program memory");
    property p_wo_read;
        cpu_read && (cpu_addr == 8'hc9 || cpu_addr == 8'hcb) |=> !cpu_rdata_valid;
    endproperty
    a_wo_read: assert property (p_wo_read)
        else $error("write-only register answered a read");
    property p_ctl_read;
        cpu_read && cpu_addr == 8'hdf |=> cpu_rdata_valid && cpu_rdata[7:2] == 6'h00
            && !cpu_rdata[0];
    endproperty
    a_ctl_read: assert property (p_ctl_read)
        else $error("control readback shows more than busy");
    property p_ram_write;
        ram_page_write |-> ram_page_sel && $past(cpu_write)
            && ram_page_offset == $past(cpu_addr[5:0]) && ram_page_wdata == $past(cpu_wdata);
    endproperty
    a_ram_write: assert property (p_ram_write)
        else $error("ram page write without matching cpu write");
    property p_busy_len;
        $fell(nvm_busy_flag) |-> busy_cnt_reg == PROGRAM_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length wrong");
    property p_prog_busy;
        nvm_program |-> nvm_busy_flag;
    endproperty
    a_prog_busy: assert property (p_prog_busy)
        else $error("programming without busy");
    property p_ctl_busy;
        nvm_busy_flag && cpu_write && cpu_addr == 8'hdf |=> $stable(nvm_standby);
    endproperty
    a_ctl_busy: assert property (p_ctl_busy)
        else $error("control changed while busy");
    property p_standby;
        !nvm_busy_flag && cpu_write && cpu_addr == 8'hdf |=> nvm_standby == $past(cpu_wdata[6]);
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby bit not taken");
endmodule

// >>> dspg_mem_model.sv
// far-side memories: program memory, ram page 2 and nvm array
`timescale 1ns/1ns
module dspg_mem_model
(
    // clock
    input wire logic clk,
    // program memory
    input wire logic [11:0] prog_addr,
    output logic [7:0] prog_rdata,
    // ram page
    input wire logic ram_page_sel,
    input wire logic ram_page_write,
    input wire logic [5:0] ram_page_offset,
    input wire logic [7:0] ram_page_wdata,
    output logic [7:0] ram_page_rdata,
    // nvm array
    input wire logic nvm_page,
    input wire logic [5:0] nvm_offset,
    input wire logic nvm_read,
    output logic [7:0] nvm_rdata,
    input wire logic nvm_program,
    input wire logic [7:0] nvm_byte_enable,
    input wire logic [63:0] nvm_program_data
);
    logic [7:0] ram_mem [64];
    logic [7:0] nvm_mem [128];
    logic [7:0] junk_reg = 8'h5a;
    logic prog_d_reg = 1'b0;
    initial foreach (nvm_mem[i]) nvm_mem[i] = 8'hff;
    assign prog_rdata = prog_addr[7:0] ^ {prog_addr[11:8], prog_addr[11:8]};
    // unselected outputs toggle every cycle so a stale byte never passes
    assign ram_page_rdata = ram_page_sel ? ram_mem[ram_page_offset] : junk_reg;
    assign nvm_rdata = nvm_read ? nvm_mem[{nvm_page, nvm_offset}] : ~junk_reg;
    always @(posedge clk)
    begin
        junk_reg <= ~{junk_reg[6:0], junk_reg[7]};
        prog_d_reg <= nvm_program;
        if (ram_page_sel && ram_page_write)
            ram_mem[ram_page_offset] <= ram_page_wdata;
        // cells commit once, at the start of a programming cycle
        if (nvm_program && !prog_d_reg)
            for (int i = 0; i < 8; i++)
                if (nvm_byte_enable[i])
                    nvm_mem[{nvm_page, nvm_offset[5:3], 3'(i)}] <= nvm_program_data[8*i +: 8];
    end
endmodule

// >>> tb.sv
// testbench: cpu-side stimulus, reference model and verdict
`timescale 1ns/1ns
module tb;
    logic clk, reset_n, cpu_read, cpu_write, cpu_rdata_valid, ram_page_sel, ram_page_write;
    logic nvm_page, nvm_read, nvm_program, nvm_busy_flag, nvm_standby;
    logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, prog_rdata, ram_page_wdata, ram_page_rdata;
    logic [7:0] nvm_rdata, nvm_byte_enable, rd_data, d, base, ctl_img;
    logic [5:0] ram_page_offset, nvm_offset;
    logic [11:0] prog_addr;
    logic [63:0] nvm_program_data;
    logic rd_valid;
    int error_cnt = 0;
    int total_checks = 0;
    int cycle_cnt = 0;
    int pg;
    logic [7:0] ram_m [64];
    logic [7:0] nvm_m [128];
    dspg_paging #(.PROGRAM_CYCLES(4)) i_dspg_paging (.clk, .reset_n, .cpu_addr, .cpu_read,
        .cpu_write, .cpu_wdata, .cpu_rdata, .cpu_rdata_valid, .prog_addr, .prog_rdata,
        .ram_page_sel, .ram_page_write, .ram_page_offset, .ram_page_wdata, .ram_page_rdata,
        .nvm_page, .nvm_offset, .nvm_read, .nvm_rdata, .nvm_program, .nvm_byte_enable,
        .nvm_program_data, .nvm_busy_flag, .nvm_standby);
    dspg_mem_model i_dspg_mem_model (.clk, .prog_addr, .prog_rdata, .ram_page_sel,
        .ram_page_write, .ram_page_offset, .ram_page_wdata, .ram_page_rdata, .nvm_page,
        .nvm_offset, .nvm_read, .nvm_rdata, .nvm_program, .nvm_byte_enable, .nvm_program_data);
    // ====
    // tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        cpu_addr <= a;
        cpu_wdata <= v;
        cpu_write <= 1'b1;
        @(posedge clk);
        cpu_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        cpu_addr <= a;
        cpu_read <= 1'b1;
        @(posedge clk);
        cpu_read <= 1'b0;
        #1;
        rd_data = cpu_rdata;
        rd_valid = cpu_rdata_valid;
    endtask
    // image first, bits 5 and 4 always cleared
    task automatic wctl(input logic [7:0] v);
        ctl_img = v & 8'hcf;
        wr(8'hdf, ctl_img);
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (nvm_busy_flag !== 1'b0 && n < 50)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check({7'h0, nvm_busy_flag}, 8'h00);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // a hang counts as a mismatch
    always @(posedge clk)
    begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 5000)
        begin
            error_cnt++;
            print_verdict();
        end
    end
    // ====
    // main sequence
    initial
    begin
        {reset_n, cpu_read, cpu_write} = 3'b000;
        cpu_addr = 8'h00;
        cpu_wdata = 8'h00;
        void'($urandom(79));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'hdf);
        check(rd_data, 8'h00);
        for (int k = 0; k < 3; k++)
        begin
            base = 8'($urandom);
            wr(8'hc9, base);
            for (int j = 0; j < 64; j += 21)
            begin
                rd(8'h40 + 8'(j));
                check(rd_data, 8'(j) ^ {base[1:0], 6'h00} ^ {2{base[5:2]}});
            end
        end
        rd(8'hc9);
        check({7'h0, rd_valid}, 8'h00);
        // a reset in mid-run must leave the window position alone
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        rd(8'h41);
        check(rd_data, 8'h01 ^ {base[1:0], 6'h00} ^ {2{base[5:2]}});
        wr(8'hcb, 8'h10 | (8'($urandom) & 8'he4));
        for (int j = 0; j < 64; j += 9)
        begin
            ram_m[j] = 8'($urandom);
            wr(8'(j), ram_m[j]);
        end
        for (int j = 0; j < 64; j += 9)
        begin
            rd(8'(j));
            check(rd_data, ram_m[j]);
        end
        foreach (nvm_m[i]) nvm_m[i] = 8'hff;
        wr(8'hcb, 8'h01);
        wctl(8'h01);
        d = 8'($urandom);
        wr(8'h05, d);
        nvm_m[5] = d;
        rd(8'hdf);
        check(rd_data, 8'h02);
        wctl(8'h41);
        wait_idle();
        check({7'h0, nvm_standby}, 8'h00);
        rd(8'h05);
        check(rd_data, d);
        wctl(8'h00);
        wr(8'h06, 8'h3c);
        check({7'h0, nvm_busy_flag}, 8'h00);
        wctl(8'h41);
        wr(8'h07, 8'h11);
        check({6'h0, nvm_standby, nvm_busy_flag}, 8'h02);
        wctl(8'h00);
        rd(8'h06);
        check(rd_data, 8'hff);
        rd(8'h07);
        check(rd_data, 8'hff);
        wr(8'hcb, 8'h02);
        pg = 64;
        wctl(8'h04);
        wr(8'h20, 8'h77);
        wctl(8'h0c);
        check({7'h0, nvm_busy_flag}, 8'h00);
        wctl(8'h05);
        for (int i = 0; i < 3; i++)
        begin
            nvm_m[pg + 24 + i + (i > 0)] = 8'($urandom);
            wr(8'(24 + i + (i > 0)), nvm_m[pg + 24 + i + (i > 0)]);
        end
        check({7'h0, nvm_busy_flag}, 8'h00);
        wctl(8'h0d);
        check({7'h0, nvm_busy_flag}, 8'h01);
        wait_idle();
        for (int a = 16; a < 40; a++)
        begin
            rd(8'(a));
            check(rd_data, nvm_m[pg + a]);
        end
        wctl(8'h09);
        check({7'h0, nvm_busy_flag}, 8'h00);
        print_verdict();
    end
endmodule
bind dspg_paging dspg_paging_props #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) i_props (.clk, .reset_n,
    .cpu_addr, .cpu_read, .cpu_write, .cpu_wdata, .cpu_rdata, .cpu_rdata_valid, .prog_addr,
    .prog_rdata, .ram_page_sel, .ram_page_write, .ram_page_offset, .ram_page_wdata,
    .nvm_program, .nvm_busy_flag, .nvm_standby);
